// ===== hw/cops_map.svh
`ifndef COPS_MAP_SVH
`define COPS_MAP_SVH

// Byte offsets of the control bytes on the management port.
`define COPS_OFS_SRC_STOP_EN   8'h03
`define COPS_OFS_BUS_STOP_EN   8'h04
`define COPS_OFS_DRIVE_MODE    8'h05
`define COPS_OFS_MODE_STATUS   8'h06
`define COPS_OFS_IDENTITY      8'h07

// Writable bits and fixed read values of the two stop enable bytes and the drive mode byte.
`define COPS_WMASK_SRC_STOP    8'h9E
`define COPS_FIXED_SRC_STOP    8'h00
`define COPS_WMASK_BUS_STOP    8'h70
`define COPS_FIXED_BUS_STOP    8'h07
`define COPS_WMASK_DRIVE       8'h8F
`define COPS_FIXED_DRIVE       8'h00

// Reset values.
`define COPS_RST_SRC_STOP      8'h00
`define COPS_RST_BUS_STOP      8'h07
`define COPS_RST_DRIVE         8'h00
`define COPS_RST_MODE_HI       4'h7
`define COPS_RST_SYNC          21'h10_0000

// Field positions inside the mode and status byte.
`define COPS_BIT_TEST_MODE     6
`define COPS_BIT_REFERENCE_OUTPUT_SECOND_STRENGTH 5
`define COPS_BIT_REFERENCE_OUTPUT_FIRST_STRENGTH 4
`define COPS_BIT_BUS_RUN       3

// Field positions inside the drive mode byte.
`define COPS_BIT_SRC_STOP_TRI  7
`define COPS_BIT_SRC_PD_TRI    3

// Field positions inside the bus stop enable byte.
`define COPS_BIT_DOT_PD_TRI    6
`define COPS_BIT_FR1_STOP_EN   5
`define COPS_BIT_FR0_STOP_EN   4

// Timing: clock period and power-up latency limit.
`define COPS_CLK_PERIOD_NS     4
`define COPS_PWRUP_LIMIT_NS    1800000
`define COPS_PD_EDGES          2'd2

`endif

// ===== hw/cops_pkg.sv
package cops_pkg;

   // Power sequencing states.
   typedef enum logic [1:0] {
      ST_RUN,
      ST_PARK,
      ST_OFF,
      ST_WAKE
   } cops_state_t;

   // One differential output pair with its enables.
   typedef struct packed {
      logic tru;
      logic tru_oe;
      logic cmp;
      logic cmp_oe;
   } cops_diff_t;

endpackage

// ===== hw/cops_ctrl.sv
`timescale 1ns/1ns
`include "cops_map.svh"
// Overview of operation
// R01 - Byte six bit 6 enters Hi-Z test mode.
// R02 - Bits 5,4 set reference drive strength.
// R03 - Stop bit 0 stops stoppable clocks cleanly.
// R04 - Stop bit 1 restarts stopped clocks cleanly.
// R05 - Bits 2:0 read latched frequency selects.
// R06 - Pin is power-good first, then request.
// R07 - Request is synchronised before any action.
// R08 - Entry after two complement rising edges.
// R09 - Single-ended outputs park low after falling.
// R10 - Pairs park at complement falling edge.
// R11 - Mode 0 drives true high, complement floats.
// R12 - Mode 1 tri-states both lines of pair.
// R13 - Clocks parked before oscillators switch off.
// R14 - Controller raises request within 10 us.
// R15 - Stable clocks within 1.8 ms.
// R16 - Floating pairs driven high on release.
// R17 - All outputs enabled within two bus clocks.
// R18 - Stop-enable bits choose stoppable outputs.
// R19 - Stop drive mode drives or floats pairs.
// R20 - Power-down drive bits per pair group.
// R21 - Dot clock pair has own drive bit.
// R22 - Two flip-flop synchroniser on the request.
// R23 - Stop changes apply at low phase boundary.
module cops_ctrl #(
   parameter int PWRUP_LIMIT_CYC = `COPS_PWRUP_LIMIT_NS / `COPS_CLK_PERIOD_NS
) (
   input  wire logic                    sys_clk_in,
   input  wire logic                    rst_n_in,
   input  wire logic                    power_good_strobe_in,
   input  wire logic [2:0]              freq_select_in,
   input  wire logic                    pll_lock_in,
   input  wire logic [7:0]              se_raw_in,
   input  wire logic [8:0]              diff_raw_in,
   input  wire logic [7:0]              reg_addr_in,
   input  wire logic [7:0]              reg_wdata_in,
   input  wire logic                    reg_wr_in,
   input  wire logic                    reg_rd_in,
   output logic      [7:0]              reg_rdata_out,
   output logic      [7:0]              se_out,
   output logic      [7:0]              se_oe_out,
   output cops_pkg::cops_diff_t [8:0]   diff_out,
   output logic      [1:0]              ref_strength_out,
   output logic                         osc_enable_out
);
   import cops_pkg::*;

   // Arbitrary neutral identity value.
   localparam logic [7:0] IDENTITY = 8'h5A;
   localparam logic [19:0] LIMIT = 20'(PWRUP_LIMIT_CYC);

   logic [1:0]  rst_sync_r;
   logic        rst_n;
   logic [20:0] sync1_r;
   logic [20:0] sync2_r;
   logic        pin_s;
   logic [2:0]  fs_s;
   logic [7:0]  se_raw_s;
   logic [8:0]  diff_raw_s;
   logic        pd_mode_r;
   logic [2:0]  fs_r;
   logic [7:0]  src_stop_r;
   logic [7:0]  bus_stop_r;
   logic [7:0]  drive_r;
   logic [3:0]  mode_r;
   logic        cpu_clock_complement_prev_r;
   logic [1:0]  edge_cnt_r;
   cops_state_t state_r;
   cops_state_t state_nxt;
   logic [19:0] wake_cnt_r;
   logic [7:0]  se_run_r;
   logic [8:0]  parked_r;
   logic        test_mode;
   logic        sw_stop;
   logic        pd_hold;
   logic        all_parked;
   logic [7:0]  se_stop;
   logic [8:0]  diff_stop;
   logic [8:0]  diff_pd_tri;
   logic [8:0]  diff_tri;

   ////////////////////////////////////////////////////////////////////////////
   // Reset release and input synchronisers.

   // Reset enters asynchronously and is released through two flip-flops.
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_sync_r <= 2'b00;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // Two flip-flops per pin; the pin resets idle high so no false power-good.
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         sync1_r <= `COPS_RST_SYNC;
         sync2_r <= `COPS_RST_SYNC;
      end else begin
         sync1_r <= {power_good_strobe_in, freq_select_in, diff_raw_in, se_raw_in}; // R07 R22
         sync2_r <= sync1_r; // R22
      end
   end
   assign se_raw_s   = sync2_r[7:0];
   assign diff_raw_s = sync2_r[16:8];
   assign fs_s       = sync2_r[19:17];
   assign pin_s      = sync2_r[20];

   ////////////////////////////////////////////////////////////////////////////
   // Power-good latch of the frequency selects.

   // The first low sample is power-good; afterwards the pin is the request.
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         pd_mode_r <= 1'b0;
         fs_r      <= 3'b000;
      end else if (!pd_mode_r && !pin_s) begin
         pd_mode_r <= 1'b1; // R06
         fs_r      <= fs_s; // R05
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port.

   // Writes keep only writable bits; reserved bits hold their fixed values.
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         src_stop_r <= `COPS_RST_SRC_STOP;
         bus_stop_r <= `COPS_RST_BUS_STOP;
         drive_r    <= `COPS_RST_DRIVE;
         mode_r     <= `COPS_RST_MODE_HI;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `COPS_OFS_SRC_STOP_EN: begin
               src_stop_r <= (reg_wdata_in & `COPS_WMASK_SRC_STOP) | `COPS_FIXED_SRC_STOP; // R18
            end
            `COPS_OFS_BUS_STOP_EN: begin
               bus_stop_r <= (reg_wdata_in & `COPS_WMASK_BUS_STOP) | `COPS_FIXED_BUS_STOP; // R18
            end
            `COPS_OFS_DRIVE_MODE: begin
               drive_r <= (reg_wdata_in & `COPS_WMASK_DRIVE) | `COPS_FIXED_DRIVE; // R19 R20
            end
            `COPS_OFS_MODE_STATUS: begin
               mode_r <= reg_wdata_in[6:3]; // R01 R02 R03 R04
            end
            default: begin
            end
         endcase
      end
   end

   // Read data is registered; unmapped offsets read zero.
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata_out <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `COPS_OFS_SRC_STOP_EN: reg_rdata_out <= src_stop_r;
            `COPS_OFS_BUS_STOP_EN: reg_rdata_out <= bus_stop_r;
            `COPS_OFS_DRIVE_MODE:  reg_rdata_out <= drive_r;
            `COPS_OFS_MODE_STATUS: reg_rdata_out <= {1'b0, mode_r, fs_r}; // R05
            `COPS_OFS_IDENTITY:    reg_rdata_out <= IDENTITY;
            default:               reg_rdata_out <= 8'h00;
         endcase
      end
   end

   assign test_mode        = mode_r[`COPS_BIT_TEST_MODE - 3];
   assign sw_stop          = !mode_r[`COPS_BIT_BUS_RUN - 3];
   assign ref_strength_out = {mode_r[`COPS_BIT_REFERENCE_OUTPUT_SECOND_STRENGTH - 3],
                              mode_r[`COPS_BIT_REFERENCE_OUTPUT_FIRST_STRENGTH - 3]}; // R02

   ////////////////////////////////////////////////////////////////////////////
   // Power-down request qualification and sequencing.

   // Complement rises when the true CPU clock falls; count edges while requested.
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         cpu_clock_complement_prev_r <= 1'b0;
         edge_cnt_r  <= 2'd0;
      end else begin
         cpu_clock_complement_prev_r <= !diff_raw_s[5];
         if (!pin_s || !pd_mode_r) begin
            edge_cnt_r <= 2'd0;
         end else if (!diff_raw_s[5] && !cpu_clock_complement_prev_r && edge_cnt_r != `COPS_PD_EDGES) begin
            edge_cnt_r <= edge_cnt_r + 2'd1; // R08
         end
      end
   end

   // Oscillators stop only once every output has reached its parked state.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_RUN:  if (edge_cnt_r == `COPS_PD_EDGES) state_nxt = ST_PARK; // R08
         ST_PARK: if (all_parked) state_nxt = ST_OFF; // R13
         ST_OFF:  if (!pin_s) state_nxt = ST_WAKE; // R07
         ST_WAKE: if (pll_lock_in || wake_cnt_r == LIMIT - 20'd1) state_nxt = ST_RUN; // R15
         default: state_nxt = ST_RUN;
      endcase
   end

   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= ST_RUN;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Wake timer bounds the wait for lock so clocks return in time.
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         wake_cnt_r <= 20'h0_0000;
      end else if (state_r == ST_WAKE) begin
         wake_cnt_r <= wake_cnt_r + 20'h0_0001; // R15
      end else begin
         wake_cnt_r <= 20'h0_0000;
      end
   end

   assign osc_enable_out = (state_r != ST_OFF); // R13
   assign pd_hold        = (state_r != ST_RUN);
   assign all_parked     = (&parked_r) && !(|se_run_r);

   ////////////////////////////////////////////////////////////////////////////
   // Output gating.

   // Bus clocks always stop; free-running ones only when enabled; refs never.
   assign se_stop = {2'b00, sw_stop && bus_stop_r[`COPS_BIT_FR1_STOP_EN],
                     sw_stop && bus_stop_r[`COPS_BIT_FR0_STOP_EN], {4{sw_stop}}}; // R03 R18

   // Pairs 0-4 serial reference, 5-7 CPU, 8 dot clock.
   assign diff_stop = {4'b0000, sw_stop && src_stop_r[7], sw_stop && src_stop_r[4],
                       sw_stop && src_stop_r[3], sw_stop && src_stop_r[2],
                       sw_stop && src_stop_r[1]}; // R18
   assign diff_pd_tri = {bus_stop_r[`COPS_BIT_DOT_PD_TRI], drive_r[2:0],
                         {5{drive_r[`COPS_BIT_SRC_PD_TRI]}}}; // R20 R21
   // While waking, floating pairs are driven high so the receiver sees a level.
   assign diff_tri = pd_hold ? (diff_pd_tri & {9{state_r != ST_WAKE}}) // R16
                             : {9'h000 | {4'h0, {5{drive_r[`COPS_BIT_SRC_STOP_TRI]}}}}; // R19

   // Single-ended gates move only while the clock is low, so pulses stay whole.
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         se_run_r <= 8'hFF;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (!se_raw_s[i]) begin
               se_run_r[i] <= !(se_stop[i] || pd_hold); // R04 R09 R23
            end
         end
      end
   end

   // Pair gates move only while the complement is low, just after its fall.
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         parked_r <= 9'h000;
      end else begin
         for (int i = 0; i < 9; i++) begin
            if (diff_raw_s[i]) begin
               parked_r[i] <= diff_stop[i] || pd_hold; // R10 R17 R23
            end
         end
      end
   end

   // Outputs are registered; test mode floats everything.
   always_ff @(posedge sys_clk_in or negedge rst_n) begin
      if (!rst_n) begin
         se_out    <= 8'h00;
         se_oe_out <= 8'h00;
         diff_out  <= '0;
      end else begin
         se_out    <= se_raw_s & se_run_r; // R09
         se_oe_out <= {8{!test_mode}}; // R01
         for (int i = 0; i < 9; i++) begin
            if (test_mode) begin
               diff_out[i] <= '0; // R01
            end else if (!parked_r[i]) begin
               diff_out[i] <= '{tru: diff_raw_s[i], tru_oe: 1'b1,
                                cmp: !diff_raw_s[i], cmp_oe: 1'b1};
            end else if (diff_tri[i]) begin
               diff_out[i] <= '0; // R12
            end else if (pd_hold) begin
               diff_out[i] <= '{tru: 1'b1, tru_oe: 1'b1, cmp: 1'b0, cmp_oe: 1'b0}; // R11
            end else begin
               diff_out[i] <= '{tru: 1'b1, tru_oe: 1'b1, cmp: 1'b0, cmp_oe: 1'b1}; // R19
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks.

   AST_TEST_HIZ: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R01
      test_mode |=> (se_oe_out == 8'h00) && !diff_out[5].tru_oe && !diff_out[0].cmp_oe)
      else $error("Test mode did not float outputs.");
   AST_STRENGTH: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R02
      (reg_wr_in && reg_addr_in == `COPS_OFS_MODE_STATUS)
      |=> ref_strength_out == $past(reg_wdata_in[5:4]))
      else $error("Reference strength did not follow write.");
   AST_STOP_BUS: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R03
      (sw_stop && !se_raw_s[0]) |=> !se_run_r[0])
      else $error("Bus clock not stopped at low phase.");
   AST_RESTART: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R04
      (!sw_stop && state_r == ST_RUN && !se_raw_s[0]) |=> se_run_r[0])
      else $error("Bus clock did not restart.");
   AST_NO_RUNT: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R23
      $changed(se_run_r[1]) |-> !$past(se_raw_s[1]))
      else $error("Gate moved during high phase.");
   AST_FS_LATCH: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R05
      $rose(pd_mode_r) |-> fs_r == $past(fs_s))
      else $error("Frequency selects not latched at power-good.");
   AST_PG_FIRST: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R06
      !pd_mode_r |-> state_r == ST_RUN)
      else $error("Power-down before power-good.");
   AST_TWO_EDGES: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R08
      (state_r == ST_RUN ##1 state_r == ST_PARK) |-> $past(edge_cnt_r) == 2'd2)
      else $error("Power-down entered without two edges.");
   AST_PARKED_OFF: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R13
      (state_r == ST_OFF) |-> all_parked && se_out == 8'h00)
      else $error("Oscillator off with clocks running.");
   AST_PD_DRIVE0: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R11
      (state_r == ST_OFF && !drive_r[1] && !test_mode) ##1 state_r == ST_OFF
      |-> diff_out[6].tru && diff_out[6].tru_oe && !diff_out[6].cmp_oe)
      else $error("Mode 0 pair not held high.");
   AST_WAKE_HIGH: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R16
      (state_r == ST_WAKE && !test_mode) ##1 state_r == ST_WAKE |-> diff_out[0].tru_oe)
      else $error("Pair left floating after release.");
   AST_WAKE_BOUND: assert property (@(posedge sys_clk_in) disable iff (!rst_n) // R15
      (state_r == ST_WAKE) |-> wake_cnt_r < LIMIT)
      else $error("Wake wait exceeded limit.");

endmodule

// ===== testbench/cops_power_host.sv
`timescale 1ns/1ns
// Behavioural far side: power management logic on the shared pin and straps,
// plus the PLL lock flag and the raw clock levels that the gates act on.
module cops_power_host (
   input  wire logic       sys_clk_in,
   input  wire logic       pg_go_in,
   input  wire logic       pd_cmd_in,
   input  wire logic [2:0] fs_in,
   input  wire logic       lock_cmd_in,
   input  wire logic [7:0] lock_dly_in,
   output logic            pin_out,
   output logic [2:0]      fs_out,
   output logic            lock_out,
   output logic [7:0]      se_raw_out,
   output logic [8:0]      diff_raw_out
);
   logic       se_ph;
   logic       df_ph;
   logic [7:0] lock_cnt;

   // Free oscillators on odd times, so no raw edge meets a sampling clock edge.
   // Periods of 7 and 5 system cycles keep sampled phases from aliasing.
   initial begin
      se_ph = 1'b0;
      df_ph = 1'b0;
      lock_out = 1'b0;
      lock_cnt = 8'h00;
   end
   initial begin
      #1;
      forever #14 se_ph = ~se_ph;
   end
   initial begin
      #1;
      forever #10 df_ph = ~df_ph;
   end
   assign se_raw_out = {8{se_ph}};
   assign diff_raw_out = {9{df_ph}};

   // The pin reads high until power-good, then carries the request level.
   // A power-down wanted from the start would be raised well inside ten microseconds.
   assign pin_out = pg_go_in ? pd_cmd_in : 1'b1;
   assign fs_out = fs_in;

   // Lock follows the command after a chosen delay, so answers can be prompt or slow.
   always @(negedge sys_clk_in) begin
      if (!lock_cmd_in) begin
         lock_cnt <= 8'h00;
         lock_out <= 1'b0;
      end else if (lock_cnt == lock_dly_in) begin
         lock_out <= 1'b1;
      end else begin
         lock_cnt <= lock_cnt + 8'h01;
      end
   end
endmodule

// ===== testbench/tb_cops_ctrl.sv
`timescale 1ns/1ns
module tb_cops_ctrl;
   import cops_pkg::*;
   localparam int         LIMIT   = 50;
   localparam logic [7:0] ID_CODE = 8'h5A; // Arbitrary identity value.
   logic             clk;
   logic             rst_n;
   logic             pg_go;
   logic             pd_cmd;
   logic             lock_cmd;
   logic [7:0]       lock_dly;
   logic [2:0]       fs;
   logic             pin;
   logic [2:0]       fs_pin;
   logic             lock;
   logic [7:0]       se_raw;
   logic [8:0]       diff_raw;
   logic [7:0]       addr;
   logic [7:0]       wdata;
   logic             wr;
   logic             rd;
   logic [7:0]       rdata;
   logic [7:0]       se;
   logic [7:0]       se_oe;
   cops_diff_t [8:0] diff;
   logic [1:0]       strength;
   logic             osc_en;
   logic             rd_pend;
   logic [1:0]       seen;
   logic [7:0]       mode;
   logic [7:0]       exp_q[$];
   int               bad_count;
   int               n_checks;
   int               seed;

   // Free-running system clock.
   initial clk = 1'b0;
   always #2 clk = ~clk;

   cops_power_host host_u (.sys_clk_in(clk), .pg_go_in(pg_go), .pd_cmd_in(pd_cmd),
      .fs_in(fs), .lock_cmd_in(lock_cmd), .lock_dly_in(lock_dly), .pin_out(pin),
      .fs_out(fs_pin), .lock_out(lock), .se_raw_out(se_raw), .diff_raw_out(diff_raw));

   cops_ctrl #(.PWRUP_LIMIT_CYC(LIMIT)) dut_u (.sys_clk_in(clk), .rst_n_in(rst_n),
      .power_good_strobe_in(pin), .freq_select_in(fs_pin), .pll_lock_in(lock),
      .se_raw_in(se_raw), .diff_raw_in(diff_raw), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
      .se_out(se), .se_oe_out(se_oe), .diff_out(diff), .ref_strength_out(strength),
      .osc_enable_out(osc_en));

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic test_done();
      if (bad_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic cycles(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   // The expected byte is noted when the read is issued.
   task automatic reg_read(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      exp_q.push_back(e);
      @(negedge clk);
      rd = 1'b0;
   endtask

   // Read data stands one cycle after the strobe; the oldest note is compared then.
   always @(posedge clk) rd_pend <= rd;
   always @(negedge clk) begin
      if (rd_pend === 1'b1) begin
         if (exp_q.size() == 0)
            chk("read note queue", 8'h01, 8'h00);
         else
            chk("reg_rdata_out", exp_q.pop_front(), rdata);
      end
   end

   // The run needs a few hundred cycles; this only trips on a hang.
   initial begin
      #80000;
      bad_count++;
      test_done();
   end

   // Main sequence.
   initial begin
      rst_n = 1'b0;
      pg_go = 1'b0;
      pd_cmd = 1'b0;
      lock_cmd = 1'b1;
      lock_dly = 8'h00;
      addr = 8'h00;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      bad_count = 0;
      n_checks = 0;
      seed = 45;
      fs = 3'($random(seed));
      cycles(10);
      rst_n = 1'b1;
      cycles(5);
      chk("ref_strength_out", 8'h03, {6'h00, strength});
      pg_go = 1'b1;
      cycles(8);
      reg_read(8'h06, {5'h07, fs});
      reg_read(8'h03, 8'h00);
      reg_read(8'h04, 8'h07);
      reg_read(8'h05, 8'h00);
      reg_read(8'h07, ID_CODE);
      reg_read(8'h10, 8'h00);
      // Every strength setting, with junk in the read-only bits.
      for (int i = 0; i < 4; i++) begin
         mode = {2'b10, i[1:0], 1'b1, 3'($random(seed))};
         reg_write(8'h06, mode);
         chk("ref_strength_out", {6'h00, mode[5:4]}, {6'h00, strength});
         reg_read(8'h06, {1'b0, mode[6:3], fs});
      end
      reg_write(8'h06, 8'h78);
      cycles(4);
      chk("se_oe_out test mode", 8'h00, se_oe);
      reg_write(8'h06, 8'h38);
      cycles(4);
      chk("se_oe_out normal", 8'hFF, se_oe);
      // Software stop with free-running and serial ref 0 enabled to stop.
      reg_write(8'h04, 8'h30);
      reg_write(8'h03, 8'h02);
      reg_write(8'h06, 8'h30);
      cycles(20);
      seen = 2'b00;
      repeat (8) begin
         cycles(3);
         seen = seen | {se[7], diff[1].tru};
         chk("se_out stopped", 8'h00, {2'b00, se[5:0]});
         chk("serial ref 0 stopped", 8'h0D, {4'h0, diff[0]});
      end
      chk("unstoppable outputs run", 8'h03, {6'h00, seen});
      reg_write(8'h05, 8'h80);
      cycles(4);
      chk("serial ref 0 enables", 8'h00, {6'h00, diff[0].tru_oe, diff[0].cmp_oe});
      reg_write(8'h06, 8'h38);
      seen = 2'b00;
      repeat (20) begin
         cycles(1);
         seen = seen | {diff[0].tru_oe, se[0]};
      end
      chk("outputs restart", 8'h03, {6'h00, seen});
      // Power-down: cpu 0, serial refs and dot float, cpu 1 and 2 are driven.
      reg_write(8'h05, 8'h09);
      reg_write(8'h04, 8'h70);
      for (int p = 0; p < 2; p++) begin
         lock_cmd = 1'b0;
         lock_dly = (p == 0) ? 8'h14 : 8'h00;
         pd_cmd = 1'b1;
         cycles(2);
         chk("osc_enable_out early", 8'h01, {7'h00, osc_en});
         for (int k = 0; k < 200 && osc_en !== 1'b0; k++) cycles(1);
         chk("osc_enable_out", 8'h00, {7'h00, osc_en});
         chk("se_out parked", 8'h00, se);
         chk("cpu 0 enables", 8'h00, {6'h00, diff[5].tru_oe, diff[5].cmp_oe});
         chk("cpu 1 parked", 8'h06, {5'h00, diff[6].tru, diff[6].tru_oe, diff[6].cmp_oe});
         chk("serial ref enables", 8'h00, {6'h00, diff[2].tru_oe, diff[2].cmp_oe});
         chk("dot enables", 8'h00, {6'h00, diff[8].tru_oe, diff[8].cmp_oe});
         pd_cmd = 1'b0;
         for (int k = 0; k < 30 && diff[5].tru_oe !== 1'b1; k++) cycles(1);
         chk("cpu 0 wake", 8'h03, {6'h00, diff[5].tru, diff[5].tru_oe});
         lock_cmd = (p == 0);
         for (int k = 0; k < LIMIT + 40 && se[7] !== 1'b1; k++) cycles(1);
         chk("ref clock back", 8'h01, {7'h00, se[7]});
         chk("osc_enable_out on", 8'h01, {7'h00, osc_en});
      end
      cycles(10);
      test_done();
   end
endmodule
